/* File: verilog/data_memory_bank_decode.sv */
`timescale 1ns/1ps
module data_memory_bank_decode
(
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire logic                                reqValid,
  input  wire logic                                reqWrite,
  input  wire data_memory_bank_decode_pkg::page_t  reqPage,
  input  wire logic [6:0]                          reqOffset,
  input  wire logic [7:0]                          reqWrData,
  input  wire logic [7:0]                          extRdData,
  input  wire logic                                instrDone,
  input  wire data_memory_bank_decode_pkg::pc_op_t pcOp,
  input  wire logic [10:0]                         instrTarget,
  input  wire logic                                timerSrcPin,
  input  wire logic                                cfgLowOscSel,
  input  wire logic                                extTimerClkIn,
  input  wire logic                                lowOscClkIn,
  output logic [7:0]                               rdData_reg,
  output logic                                     rdValid_reg,
  output logic                                     extStrobe_reg,
  output logic                                     extWrite_reg,
  output data_memory_bank_decode_pkg::page_t       extPage_reg,
  output logic [4:0]                               extOffset_reg,
  output logic [7:0]                               extWrData_reg,
  output logic [7:0]                               statusValue_reg,
  output logic [10:0]                              pcValue_reg,
  output logic                                     pushValid_reg,
  output logic [10:0]                              pushAddr_reg,
  output logic [7:0]                               timerCount_reg
);
  import data_memory_bank_decode_pkg::*;

  function automatic logic [6:0] ramIndex(input logic [1:0] bank,
                                          input logic [6:0] off);
    logic [6:0] low;
    low = 7'(off - RAM_FIRST);
    if ((bank == BANK_ONE || bank == BANK_THREE) && off < RAM_SHARED)
      ramIndex = 7'(low + RAM_BANK1_BASE);
    else
      ramIndex = low;
  endfunction

  logic [7:0] ramMem_reg [RAM_DEPTH];
  logic [7:0] ramMem_next [RAM_DEPTH];
  logic [7:0] fsp_reg, fsp_next, status_next;
  logic [2:0] program_counter_high_buffer_reg, program_counter_high_buffer_next;
  logic       readPend_reg, readPend_next, useExt_reg, useExt_next;
  logic [7:0] intRd_reg, intRd_next, rdData_next;
  logic       extStrobe_next, extWrite_next;
  page_t      extPage_next;
  logic [4:0] extOffset_next;
  logic [7:0] extWrData_next;
  logic [6:0] effOff, ramIdx;
  logic [1:0] bank;
  logic       isIndirect, ramHit, tmrWrEn, pclWrEn, hit, isExt;

  always_comb
  begin
    ramMem_next    = ramMem_reg;
    fsp_next       = fsp_reg;
    status_next    = statusValue_reg;
    program_counter_high_buffer_next    = program_counter_high_buffer_reg;
    intRd_next     = ZERO_BYTE;
    useExt_next    = 1'b0;
    readPend_next  = reqValid && !reqWrite;
    rdData_next    = useExt_reg ? extRdData : intRd_reg;
    extStrobe_next = 1'b0;
    extWrite_next  = 1'b0;
    extPage_next   = extPage_reg;
    extOffset_next = extOffset_reg;
    extWrData_next = extWrData_reg;
    tmrWrEn        = 1'b0;
    pclWrEn        = 1'b0;
    ramHit         = 1'b0;
    hit            = 1'b0;
    isExt          = 1'b0;
    bank = statusValue_reg[BANK_HI:BANK_LO];
    isIndirect = reqPage == PAGE_MAIN && reqOffset == OFF_INDIRECT;
    // direct offset from opcode, indirect from pointer
    effOff = isIndirect ? fsp_reg[6:0] : reqOffset;
    ramIdx = ramIndex(bank, effOff);
    // pages chosen only by the dedicated access kind
    if (reqPage == PAGE_MAIN)
    begin
      if (effOff > SFR_LAST)
        ramHit = 1'b1;
      else
        // pointer at the port itself reaches nothing
        hit = MAIN_SFR_MASK[effOff[4:0]] && effOff != OFF_INDIRECT;
      // bank bits unused below 0x20
      isExt = hit && effOff != OFF_TIMER && effOff != OFF_PC_LOW
              && effOff != OFF_STATUS && effOff != OFF_FSP
              && effOff != OFF_PC_HIGH_BUF;
    end
    else if (reqPage == PAGE_AUX_ONE)
    begin
      // bank bits ignored here
      hit = effOff <= AUX_ONE_LAST && AUX_ONE_MASK[effOff[3:0]];
      isExt = hit;
    end
    else
    begin
      hit = effOff <= AUX_TWO_LAST && AUX_TWO_MASK[effOff[4:0]];
      isExt = hit;
    end
    if (reqValid)
    begin
      if (ramHit)
      begin
        if (reqWrite)
          ramMem_next[ramIdx] = reqWrData;
        intRd_next = ramMem_reg[ramIdx];
      end
      else if (isExt)
      begin
        extStrobe_next = 1'b1;
        extWrite_next  = reqWrite;
        extPage_next   = reqPage;
        extOffset_next = effOff[4:0];
        extWrData_next = reqWrData;
        useExt_next    = !reqWrite;
      end
      else if (hit)
      begin
        if (effOff == OFF_TIMER)
        begin
          tmrWrEn    = reqWrite;
          intRd_next = timerCount_reg;
        end
        else if (effOff == OFF_PC_LOW)
        begin
          pclWrEn    = reqWrite;
          intRd_next = pcValue_reg[7:0];
        end
        else if (effOff == OFF_STATUS)
        begin
          if (reqWrite)
            status_next = reqWrData;
          intRd_next = statusValue_reg;
        end
        else if (effOff == OFF_FSP)
        begin
          if (reqWrite)
            fsp_next = reqWrData;
          intRd_next = fsp_reg;
        end
        else if (reqWrite)
          program_counter_high_buffer_next = reqWrData[2:0];  // write-only, reads zero
      end
      // holes fall through: no store, zero read
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < RAM_DEPTH; i++)
        ramMem_reg[i] <= ZERO_BYTE;
      fsp_reg         <= FSP_RESET;
      statusValue_reg <= STATUS_RESET;
      program_counter_high_buffer_reg      <= PCH_RESET;
      readPend_reg    <= 1'b0;
      useExt_reg      <= 1'b0;
      intRd_reg       <= ZERO_BYTE;
      rdData_reg      <= ZERO_BYTE;
      rdValid_reg     <= 1'b0;
      extStrobe_reg   <= 1'b0;
      extWrite_reg    <= 1'b0;
      extPage_reg     <= PAGE_MAIN;
      extOffset_reg   <= 5'h00;
      extWrData_reg   <= ZERO_BYTE;
    end
    else
    begin
      ramMem_reg      <= ramMem_next;
      fsp_reg         <= fsp_next;
      statusValue_reg <= status_next;
      program_counter_high_buffer_reg      <= program_counter_high_buffer_next;
      readPend_reg    <= readPend_next;
      useExt_reg      <= useExt_next;
      intRd_reg       <= intRd_next;
      rdData_reg      <= rdData_next;
      rdValid_reg     <= readPend_reg;
      extStrobe_reg   <= extStrobe_next;
      extWrite_reg    <= extWrite_next;
      extPage_reg     <= extPage_next;
      extOffset_reg   <= extOffset_next;
      extWrData_reg   <= extWrData_next;
    end
  end

  logic [10:0] pcNext, pushAddr_next;
  logic        pushValid_next;

  always_comb
  begin
    pcNext         = pcValue_reg;
    pushValid_next = 1'b0;
    pushAddr_next  = pushAddr_reg;
    if (pclWrEn)
      pcNext = {program_counter_high_buffer_reg, reqWrData};
    else if (instrDone)
    begin
      case (pcOp)
        PC_STEP: pcNext = pcValue_reg + PC_ONE;
        PC_JUMP: pcNext = instrTarget;
        PC_CALL:
        begin
          pcNext         = instrTarget;
          pushValid_next = 1'b1;
          pushAddr_next  = pcValue_reg + PC_ONE;
        end
        default: pcNext = pcValue_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pcValue_reg   <= PC_RESET;
      pushValid_reg <= 1'b0;
      pushAddr_reg  <= PC_RESET;
    end
    else
    begin
      pcValue_reg   <= pcNext;
      pushValid_reg <= pushValid_next;
      pushAddr_reg  <= pushAddr_next;
    end
  end

  // both timer pins are asynchronous: two stages, then an edge stage
  logic [2:0] pinSync_reg, pinSync_next, oscSync_reg, oscSync_next;
  logic [7:0] timerNext;
  logic       timerTick;

  always_comb
  begin
    pinSync_next = {pinSync_reg[1:0], extTimerClkIn};
    oscSync_next = {oscSync_reg[1:0], lowOscClkIn};
    if (timerSrcPin)
      timerTick = pinSync_reg[1] && !pinSync_reg[2];
    else if (cfgLowOscSel)
      timerTick = oscSync_reg[1] && !oscSync_reg[2];
    else
      timerTick = instrDone;
    timerNext = timerCount_reg;
    // a write wins over a tick in the same cycle
    if (tmrWrEn)
      timerNext = reqWrData;
    else if (timerTick)
      timerNext = timerCount_reg + ONE_BYTE;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinSync_reg    <= 3'h0;
      oscSync_reg    <= 3'h0;
      timerCount_reg <= ZERO_BYTE;
    end
    else
    begin
      pinSync_reg    <= pinSync_next;
      oscSync_reg    <= oscSync_next;
      timerCount_reg <= timerNext;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sfrAlias_a: assert property (
    reqValid && !reqWrite && reqPage == PAGE_MAIN && reqOffset == OFF_STATUS
    |=> ##1 rdData_reg == $past(statusValue_reg, 2))
    else $error("status read not aliased");
  ramStore_a: assert property (
    reqValid && reqWrite && ramHit
    |=> ramMem_reg[$past(ramIdx)] == $past(reqWrData))
    else $error("ram write lost");
  ramAlias_a: assert property (
    reqValid && ramHit && bank == BANK_THREE && effOff < RAM_SHARED
    |-> ramIdx == 7'(effOff + RAM_BANK1_BASE - RAM_FIRST))
    else $error("bank three alias wrong");
  holeRead_a: assert property (
    reqValid && !reqWrite && reqPage == PAGE_MAIN && reqOffset == 7'h07
    |=> !extStrobe_reg ##1 rdValid_reg && rdData_reg == ZERO_BYTE)
    else $error("hole not empty");
  auxOneGap_a: assert property (
    reqValid && reqPage == PAGE_AUX_ONE && reqOffset == 7'h07
    |=> !extStrobe_reg)
    else $error("aux one gap decoded");
  auxTwoEnd_a: assert property (
    reqValid && reqPage == PAGE_AUX_TWO && reqOffset == AUX_TWO_LAST
    |=> extStrobe_reg && extPage_reg == PAGE_AUX_TWO
        && extOffset_reg == 5'h18)
    else $error("aux two end missed");
  auxBank_a: assert property (
    reqValid && reqPage != PAGE_MAIN && isExt
    |=> extOffset_reg == $past(reqOffset[4:0]))
    else $error("aux offset bent by bank");
  indirect_a: assert property (
    isIndirect |-> effOff == fsp_reg[6:0])
    else $error("indirect not redirected");
  timerLive_a: assert property (
    reqValid && !reqWrite && reqPage == PAGE_MAIN && reqOffset == OFF_TIMER
    |=> ##1 rdData_reg == $past(timerCount_reg, 2))
    else $error("timer read stale");
  timerLoad_a: assert property (
    tmrWrEn |=> timerCount_reg == $past(reqWrData))
    else $error("timer write lost");
  pcStep_a: assert property (
    instrDone && pcOp == PC_STEP && !pclWrEn
    |=> pcValue_reg == $past(pcValue_reg) + PC_ONE)
    else $error("pc did not step");
  pcHigh_a: assert property (
    pclWrEn |=> pcValue_reg == {$past(program_counter_high_buffer_reg), $past(reqWrData)})
    else $error("pc high not from buffer");
  pcJump_a: assert property (
    instrDone && pcOp == PC_JUMP && !pclWrEn
    |=> pcValue_reg == $past(instrTarget) && !pushValid_reg)
    else $error("jump target wrong");
  pcCall_a: assert property (
    instrDone && pcOp == PC_CALL && !pclWrEn
    |=> pushValid_reg && pushAddr_reg == $past(pcValue_reg) + PC_ONE)
    else $error("call push wrong");
  coverExtRead: cover property (
    reqValid && !reqWrite && isExt ##2 rdValid_reg);
  coverCall: cover property (pushValid_reg);
  coverPinTick: cover property (timerSrcPin && timerTick);
endmodule

/* File: verilog/data_memory_bank_decode_pkg.sv */
package data_memory_bank_decode_pkg;
  localparam int          DATA_W          = 8;
  localparam int          OFF_W           = 7;
  localparam int          PC_W            = 11;
  localparam int          PCH_W           = 3;
  localparam int          RAM_DEPTH       = 128;
  localparam logic [6:0]  OFF_INDIRECT    = 7'h00;
  localparam logic [6:0]  OFF_TIMER       = 7'h01;
  localparam logic [6:0]  OFF_PC_LOW      = 7'h02;
  localparam logic [6:0]  OFF_STATUS      = 7'h03;
  localparam logic [6:0]  OFF_FSP         = 7'h04;
  localparam logic [6:0]  OFF_PC_HIGH_BUF = 7'h0A;
  localparam logic [6:0]  SFR_LAST        = 7'h1F;
  localparam logic [6:0]  RAM_FIRST       = 7'h20;
  localparam logic [6:0]  RAM_SHARED      = 7'h40;
  localparam logic [6:0]  RAM_BANK1_BASE  = 7'h60;
  localparam logic [6:0]  AUX_ONE_LAST    = 7'h0F;
  localparam logic [6:0]  AUX_TWO_LAST    = 7'h18;
  localparam logic [31:0] MAIN_SFR_MASK   = 32'h9FFFDF7F;
  localparam logic [15:0] AUX_ONE_MASK    = 16'hD660;
  localparam logic [24:0] AUX_TWO_MASK    = 25'h17FFFFF;
  localparam logic [1:0]  BANK_ONE        = 2'h1;
  localparam logic [1:0]  BANK_THREE      = 2'h3;
  localparam int          BANK_HI         = 7;
  localparam int          BANK_LO         = 6;
  localparam logic [7:0]  STATUS_RESET    = 8'h18;
  localparam logic [7:0]  FSP_RESET       = 8'h00;
  localparam logic [2:0]  PCH_RESET       = 3'h0;
  localparam logic [10:0] PC_RESET        = 11'h000;
  localparam logic [10:0] PC_ONE          = 11'h001;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
  localparam logic [7:0]  ONE_BYTE        = 8'h01;
  typedef enum logic [1:0] {PAGE_MAIN, PAGE_AUX_ONE, PAGE_AUX_TWO} page_t;
  typedef enum logic [1:0] {PC_HOLD, PC_STEP, PC_JUMP, PC_CALL} pc_op_t;
endpackage

/* File: verification/data_memory_bank_decode_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errCount++; \
  $display("[FAIL] %0t got=%0h exp=%0h", $time, g, e); end end
module data_memory_bank_decode_tb;
  import data_memory_bank_decode_pkg::*;
  logic        core_clk, reset_n, reqValid, reqWrite, instrDone;
  logic        timerSrcPin, cfgLowOscSel, extTimerClkIn, lowOscClkIn;
  page_t       reqPage, extPage_reg;
  pc_op_t      pcOp;
  logic [6:0]  reqOffset;
  logic [7:0]  reqWrData, extRdData, rdData_reg, statusValue_reg;
  logic [7:0]  extWrData_reg, timerCount_reg;
  logic        rdValid_reg, extStrobe_reg, extWrite_reg, pushValid_reg;
  logic [4:0]  extOffset_reg;
  logic [10:0] instrTarget, pcValue_reg, pushAddr_reg;
  logic [7:0]  mRam [RAM_DEPTH];
  logic [7:0]  mStat, mPtr, mTmr;
  logic [10:0] mPc;
  logic [2:0]  mPch;
  logic [31:0] lfsr;
  logic [31:0] r;
  int          errCount, nCompared;

  data_memory_bank_decode i_dut (.core_clk, .reset_n, .reqValid, .reqWrite,
    .reqPage, .reqOffset, .reqWrData, .extRdData, .instrDone, .pcOp,
    .instrTarget, .timerSrcPin, .cfgLowOscSel, .extTimerClkIn, .lowOscClkIn,
    .rdData_reg, .rdValid_reg, .extStrobe_reg, .extWrite_reg, .extPage_reg,
    .extOffset_reg, .extWrData_reg, .statusValue_reg, .pcValue_reg,
    .pushValid_reg, .pushAddr_reg, .timerCount_reg);

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic closeOut();
    $display("compared %0d errors %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // k: 0 empty, 1 external, 2 internal, 3 ram
  task automatic acc(input logic w, input logic [1:0] pg,
                     input logic [6:0] off, input logic [7:0] d);
    logic [6:0] e;
    logic [7:0] x;
    logic [7:0] q;
    int         k;
    int         ix;
    e = (pg == 2'h0 && off == 7'h00) ? mPtr[6:0] : off;
    if (pg == 2'h1)
      k = (e inside {7'h05, 7'h06, 7'h09, 7'h0A, 7'h0C, 7'h0E, 7'h0F});
    else if (pg == 2'h2)
      k = (e <= 7'h18 && e != 7'h17);
    else if (e inside {7'h00, 7'h07, 7'h0D, 7'h1D, 7'h1E})
      k = 0;
    else if (e >= 7'h20)
      k = 3;
    else
      k = (e inside {7'h01, 7'h02, 7'h03, 7'h04, 7'h0A}) ? 2 : 1;
    // banks 1 and 3 share the low ram window
    ix = int'(e) - 32 + ((mStat[6] && e < 7'h40) ? 96 : 0);
    q = 8'h00;
    if (k == 3)
      q = mRam[ix];
    if (k == 2)
      q = e == 7'h01 ? mTmr : e == 7'h02 ? mPc[7:0] :
          e == 7'h03 ? mStat : e == 7'h04 ? mPtr : 8'h00;
    @(posedge core_clk);
    #1;
    reqValid = 1'b1;
    reqWrite = w;
    reqPage = page_t'(pg);
    reqOffset = off;
    reqWrData = d;
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
    reqWrData = ~d;
    x = 8'(rnd());
    extRdData = x;
    `CHK(extStrobe_reg, 1'(k == 1))
    if (k == 1)
    begin
      q = x;
      `CHK(extWrite_reg, w)
      `CHK(extPage_reg, page_t'(pg))
      `CHK(extOffset_reg, e[4:0])
      if (w)
        `CHK(extWrData_reg, d)
    end
    if (w && k == 3)
      mRam[ix] = d;
    if (w && k == 2)
      case (e)
        7'h01: mTmr = d;
        7'h02: mPc = {mPch, d};
        7'h03: mStat = d;
        7'h04: mPtr = d;
        default: mPch = d[2:0];
      endcase
    @(posedge core_clk);
    #1;
    extRdData = ~x;
    `CHK(rdValid_reg, ~w)
    if (!w)
      `CHK(rdData_reg, q)
    if (!w)
      `CHK(rdData_reg, q)
    `CHK(pcValue_reg, mPc)
    `CHK(statusValue_reg, mStat)
  endtask

  task automatic ins(input pc_op_t op, input logic [10:0] t);
    logic [10:0] old;
    old = mPc;
    @(posedge core_clk);
    #1;
    instrDone = 1'b1;
    pcOp = op;
    instrTarget = t;
    @(posedge core_clk);
    #1;
    instrDone = 1'b0;
    instrTarget = ~t;
    if (op == PC_STEP)
      mPc = mPc + 11'h001;
    if (op == PC_JUMP || op == PC_CALL)
      mPc = t;
    if (!timerSrcPin && !cfgLowOscSel)
      mTmr = mTmr + 8'h01;
    `CHK(pcValue_reg, mPc)
    `CHK(pushValid_reg, 1'(op == PC_CALL))
    if (op == PC_CALL)
      `CHK(pushAddr_reg, old + 11'h001)
  endtask

  // slow edges so the synchroniser sees every one
  task automatic pulse(input logic low, input int n);
    repeat (n)
    begin
      repeat (3) @(posedge core_clk);
      #1;
      lowOscClkIn = low;
      extTimerClkIn = ~low;
      repeat (3) @(posedge core_clk);
      #1;
      lowOscClkIn = 1'b0;
      extTimerClkIn = 1'b0;
    end
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  initial
  begin
    {reset_n, reqValid, reqWrite, instrDone, cfgLowOscSel} = 5'h00;
    {extTimerClkIn, lowOscClkIn, reqOffset, reqWrData} = 17'h00000;
    {extRdData, instrTarget} = 19'h00000;
    timerSrcPin = 1'b1;
    reqPage = PAGE_MAIN;
    pcOp = PC_HOLD;
    lfsr = 32'h2A10;
    mStat = STATUS_RESET;
    mPtr = FSP_RESET;
    mTmr = 8'h00;
    mPc = PC_RESET;
    mPch = PCH_RESET;
    foreach (mRam[i])
      mRam[i] = 8'h00;
    errCount = 0;
    nCompared = 0;
    repeat (12) @(posedge core_clk);
    `CHK(statusValue_reg, STATUS_RESET)
    `CHK(pcValue_reg, PC_RESET)
    `CHK(timerCount_reg, 8'h00)
    #1;
    reset_n = 1'b1;
    repeat (400)
    begin
      r = rnd();
      // bias toward pointer, status and indirect accesses
      acc(r[0], r[2:1] == 2'h3 ? 2'h0 : r[2:1],
          r[31:29] == 3'h0 ? 7'h00 : r[31:29] == 3'h1 ? 7'h03 :
          r[31:29] == 3'h2 ? 7'h04 :
          (r[2:1] != 2'h0 ? {2'h0, r[20:16]} : r[22:16]),
          r[15:8]);
    end
    for (int k = 0; k < 12; k++)
      ins(pc_op_t'(k % 4), 11'(rnd()));
    acc(1'b1, 2'h0, 7'h01, 8'hFE);
    pulse(1'b0, 4);
    mTmr = mTmr + 8'h04;
    `CHK(timerCount_reg, mTmr)
    timerSrcPin = 1'b0;
    cfgLowOscSel = 1'b1;
    pulse(1'b0, 2);
    pulse(1'b1, 3);
    mTmr = mTmr + 8'h03;
    `CHK(timerCount_reg, mTmr)
    cfgLowOscSel = 1'b0;
    repeat (5) ins(PC_STEP, 11'h000);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(timerCount_reg, mTmr)
    acc(1'b0, 2'h0, 7'h01, 8'h00);
    closeOut();
  end

  initial
  begin
    #500000;
    errCount++;
    closeOut();
  end
endmodule
